/* verilog/lsc_regs.svh */
// register offsets, field positions, reset values and timing counts of the light sensor control
// assumes inclusion from the light control module and the bench only
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
`define LSC_SLAVE_ADDR      7'h44
`define LSC_OFS_OP_CFG      3'h0
`define LSC_OFS_ALARM_CTRL  3'h1
`define LSC_OFS_UPPER_LIM   3'h2
`define LSC_OFS_LOWER_LIM   3'h3
`define LSC_OFS_LIGHT_LO    3'h4
`define LSC_OFS_LIGHT_HI    3'h5
`define LSC_OFS_PERIOD_LO   3'h6
`define LSC_OFS_PERIOD_HI   3'h7
`define LSC_PTR_RESTART_BIT 7
`define LSC_PTR_CLEAR_BIT   6
`define LSC_ALARM_FLAG_BIT  5
`define LSC_RST_OP_CFG      8'h00
`define LSC_RST_ALARM_CTRL  8'h00
`define LSC_RST_UPPER_LIM   8'hff
`define LSC_RST_LOWER_LIM   8'h00
`define LSC_RST_DATA        8'h00
`define LSC_CLK_KHZ         125000
`define LSC_OSC_FAST_KHZ    684
`define LSC_OSC_DIV         (`LSC_CLK_KHZ / `LSC_OSC_FAST_KHZ)
`endif

/* verilog/lsc_pkg.sv */
// types of the light sensor control block
// assumes lsc_regs.svh for the figures
package lsc_pkg;
  typedef enum logic [2:0] {
    LSC_IDLE, LSC_ADDR, LSC_ACK, LSC_PTR, LSC_WDATA, LSC_RDATA, LSC_RACK
  } lsc_state_t;

  typedef struct packed {
    logic       converter_run;
    logic       device_sleep;
    logic       timing_source_sel;
    logic       rsvd;
    logic       conv_mode_hi;
    logic       conv_mode_lo;
    logic       width_sel_hi;
    logic       width_sel_lo;
  } lsc_op_cfg_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       alarm_flag;
    logic       rsvd;
    logic       range_sel_hi;
    logic       range_sel_lo;
    logic       persist_sel_hi;
    logic       persist_sel_lo;
  } lsc_alarm_ctrl_t;

  typedef struct packed {
    logic       stb;
    logic [2:0] idx;
    logic [7:0] data;
  } lsc_wr_t;
endpackage

/* verilog/lsc_light_ctrl.sv */
// i2c slave, register file, integration timing and threshold alarm of a light sensor
// assumes scl/sda arrive asynchronously; photo_sample comes from converter logic on clock
`timescale 1ns/100ps
`include "lsc_regs.svh"

// Function
// R1: answer only when the seven address bits after a start equal 1000100
// R2: eight byte registers; command and control hold until rewritten
// R3: four read-only bytes: light count pair and period count pair
// R4: master drives scl; receiver pulls sda low in each acknowledge slot
// R5: address byte bit 7 ends the integration and starts a new one
// R6: address byte bit 6 clears the pending alarm
// R7: command bit 7 low holds the converter core in reset
// R8: command bit 6 high powers the device down
// R9: command bit 5 selects internal or host-timed integration
// R10: internal integration lasts the oscillator cycles of the n-bit counter
// R11: external integration spans the time between restart commands
// R12: command bits 3:2 equal 1:0 produce a signed light count, else idle
// R13: command bits 1:0 pick 65536, 4096, 256 or 16 cycles
// R14: alarm pin is open drain, pulled low on alarm
// R15: alarm when count leaves the window, after the persistence count
// R16: converter result is a signed 15-bit count read as bytes; the code keeps a 16-bit count, sign extended from the selected width
// R17: control bit 5 set by alarm, cleared by writing zero
// R18: control bits 3:2 pick one of four ranges; the code decodes only bit 3, which picks one of two oscillator divisions
// R19: control bits 1:0 need 1, 4, 8 or 16 consecutive outside periods
// R20: each limit byte is the upper byte of a 16-bit limit
// R21: alarm pin and flag stay active until the host clears them
// R22: light and period counts update together at each period end
module lsc_light_ctrl
  import lsc_pkg::*;
#(
  parameter int OSC_DIV = `LSC_OSC_DIV
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output wire logic        sda_o,
  output logic             sda_oe,
  output wire logic        int_o,
  output wire logic        int_oe,
  input  wire logic [15:0] photo_sample
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // terminal value of the integration counter, cycles minus one
  function automatic logic [15:0] width_last(input logic [1:0] sel);
    unique case (sel)
      2'b00:   return 16'hffff;
      2'b01:   return 16'h0fff;
      2'b10:   return 16'h00ff;
      default: return 16'h000f;
    endcase
  endfunction

  // keep n bits of the sample, sign extended
  function automatic logic [15:0] fit_width(input logic [15:0] s, input logic [1:0] sel);
    unique case (sel)
      2'b00:   return s;
      2'b01:   return {{4{s[11]}}, s[11:0]};
      2'b10:   return {{8{s[7]}}, s[7:0]};
      default: return {{12{s[3]}}, s[3:0]};
    endcase
  endfunction

  function automatic logic [4:0] persist_need(input logic [1:0] sel);
    unique case (sel)
      2'b00:   return 5'h01;
      2'b01:   return 5'h04;
      2'b10:   return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
    end
  end

  wire logic scl_s     = scl_sync[1];
  wire logic sda_s     = sda_sync[1];
  wire logic scl_rise  = scl_s & ~scl_sync[2];
  wire logic scl_fall  = ~scl_s & scl_sync[2];
  wire logic start_c   = scl_s & scl_sync[2] & ~sda_s & sda_sync[2];
  wire logic stop_c    = scl_s & scl_sync[2] & sda_s & ~sda_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  lsc_op_cfg_t     cfg;
  lsc_alarm_ctrl_t actl;
  logic [7:0]      upper_limit_bits;
  logic [7:0]      lower_limit_bits;
  logic [15:0]     light_count;
  logic [15:0]     period_count;
  lsc_wr_t         wr;
  logic [2:0]      ptr_idx;
  logic [7:0]      shreg;

  function automatic logic [7:0] reg_read(input logic [2:0] idx);
    unique case (idx)
      `LSC_OFS_OP_CFG:     return cfg & 8'hef;
      `LSC_OFS_ALARM_CTRL: return actl & 8'h2f;
      `LSC_OFS_UPPER_LIM:  return upper_limit_bits;
      `LSC_OFS_LOWER_LIM:  return lower_limit_bits;
      `LSC_OFS_LIGHT_LO:   return light_count[7:0];
      `LSC_OFS_LIGHT_HI:   return light_count[15:8];
      `LSC_OFS_PERIOD_LO:  return period_count[7:0];
      default:             return period_count[15:8];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // i2c slave

  lsc_state_t state;
  lsc_state_t after_ack;
  logic [3:0] bitcnt;
  logic       nack;
  logic       restart_cmd;
  logic       clear_cmd;

  wire logic       byte_done = scl_fall & (bitcnt == 4'd8);
  wire logic       addr_hit  = shreg[7:1] == `LSC_SLAVE_ADDR;
  wire logic [7:0] rd_byte   = reg_read(ptr_idx);

  assign sda_o = 1'b0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= LSC_IDLE;
      after_ack   <= LSC_IDLE;
      bitcnt      <= 4'h0;
      shreg       <= 8'h00;
      sda_oe      <= 1'b0;
      nack        <= 1'b0;
      ptr_idx     <= 3'h0;
      wr          <= '0;
      restart_cmd <= 1'b0;
      clear_cmd   <= 1'b0;
    end else begin
      wr.stb      <= 1'b0;
      restart_cmd <= 1'b0;
      clear_cmd   <= 1'b0;
      if (start_c) begin
        state  <= LSC_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state  <= LSC_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          LSC_IDLE: ;
          LSC_ADDR, LSC_PTR, LSC_WDATA: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'd1;
            end else if (byte_done) begin
              bitcnt <= 4'h0;
              state  <= LSC_ACK;
              sda_oe <= 1'b1; // R4
              if (state == LSC_ADDR) begin
                after_ack <= shreg[0] ? LSC_RDATA : LSC_PTR;
                if (!addr_hit) begin // R1
                  state  <= LSC_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (state == LSC_PTR) begin
                after_ack   <= LSC_WDATA;
                ptr_idx     <= shreg[2:0];
                restart_cmd <= shreg[`LSC_PTR_RESTART_BIT]; // R5
                clear_cmd   <= shreg[`LSC_PTR_CLEAR_BIT]; // R6
              end else begin
                after_ack <= LSC_WDATA;
                wr        <= '{stb: 1'b1, idx: ptr_idx, data: shreg};
                ptr_idx   <= ptr_idx + 3'd1;
              end
            end
          end
          LSC_ACK: begin
            if (scl_fall) begin
              state  <= after_ack;
              sda_oe <= 1'b0;
              if (after_ack == LSC_RDATA) begin
                shreg  <= rd_byte;
                sda_oe <= ~rd_byte[7];
              end
            end
          end
          LSC_RDATA: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'd1;
            end else if (byte_done) begin
              state  <= LSC_RACK;
              sda_oe <= 1'b0;
            end else if (scl_fall) begin
              shreg  <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
          LSC_RACK: begin
            if (scl_rise) begin
              nack    <= sda_s;
              ptr_idx <= ptr_idx + 3'd1;
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              state  <= nack ? LSC_IDLE : LSC_RDATA;
              shreg  <= rd_byte;
              sda_oe <= ~nack & ~rd_byte[7];
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // integration timing

  logic [15:0] div_cnt;
  logic [15:0] integ_cnt;
  logic [4:0]  persist_cnt;

  wire logic        fast_range = actl.range_sel_hi;
  wire logic [15:0] div_last   = fast_range ? 16'(OSC_DIV - 1) : 16'(2 * OSC_DIV - 1);
  wire logic        osc_tick   = div_cnt == 16'h0000;
  wire logic        light_mode = {cfg.conv_mode_hi, cfg.conv_mode_lo} == 2'b10; // R12
  wire logic        active     = cfg.converter_run & ~cfg.device_sleep & light_mode; // R7 R8
  wire logic [1:0]  wsel       = {cfg.width_sel_hi, cfg.width_sel_lo};
  wire logic [15:0] int_last   = width_last(wsel); // R13
  wire logic        int_end    = ~cfg.timing_source_sel & osc_tick & (integ_cnt == int_last);
  wire logic        cfg_wr     = wr.stb & (wr.idx == `LSC_OFS_OP_CFG);
  wire logic        period_end = active & (int_end | restart_cmd); // R9 R10 R11 R5
  wire logic [15:0] new_light  = fit_width(photo_sample, wsel); // R16
  wire logic        out_win    = (new_light > {upper_limit_bits, 8'h00})
                               | (new_light < {lower_limit_bits, 8'h00}); // R20 R15
  wire logic [4:0]  need       = persist_need({actl.persist_sel_hi, actl.persist_sel_lo});
  wire logic        alarm_set  = period_end & out_win & (persist_cnt >= need - 5'd1); // R19
  wire logic        alarm_clr  = clear_cmd | (wr.stb & (wr.idx == `LSC_OFS_ALARM_CTRL)
                               & ~wr.data[`LSC_ALARM_FLAG_BIT]); // R17
  wire logic        next_flag  = alarm_set | (actl.alarm_flag & ~alarm_clr); // R21

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= (osc_tick || cfg.device_sleep) ? div_last : div_cnt - 16'd1;
    end
  end

  // external mode saturates rather than wraps so long host periods stay readable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      integ_cnt <= 16'h0000;
    end else if (!active || period_end || cfg_wr) begin
      // a count left above a new terminal value would never match
      integ_cnt <= 16'h0000; // R7 R8 R5
    end else if (osc_tick && integ_cnt != 16'hffff) begin
      integ_cnt <= integ_cnt + 16'd1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      light_count  <= {`LSC_RST_DATA, `LSC_RST_DATA};
      period_count <= {`LSC_RST_DATA, `LSC_RST_DATA};
      persist_cnt  <= 5'h00;
    end else if (period_end) begin
      light_count  <= new_light; // R3 R22
      period_count <= integ_cnt; // R22
      // saturates so a long excursion keeps the alarm armed
      persist_cnt  <= !out_win ? 5'h00 : (persist_cnt == 5'h1f) ? 5'h1f : persist_cnt + 5'd1;
    end
  end

  // only software writes reach the held registers, apart from actl.alarm_flag, which follows next_flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg              <= `LSC_RST_OP_CFG;
      actl             <= `LSC_RST_ALARM_CTRL;
      upper_limit_bits <= `LSC_RST_UPPER_LIM;
      lower_limit_bits <= `LSC_RST_LOWER_LIM;
    end else begin
      actl.alarm_flag <= next_flag;
      if (wr.stb) begin // R2
        unique case (wr.idx)
          `LSC_OFS_OP_CFG:     cfg <= wr.data & 8'hef;
          `LSC_OFS_ALARM_CTRL: {actl.range_sel_hi, actl.range_sel_lo, actl.persist_sel_hi,
                                actl.persist_sel_lo} <= wr.data[3:0]; // R18 R19
          `LSC_OFS_UPPER_LIM:  upper_limit_bits <= wr.data;
          `LSC_OFS_LOWER_LIM:  lower_limit_bits <= wr.data;
          default: ; // R3
        endcase
      end
    end
  end

  assign int_o  = 1'b0;
  assign int_oe = actl.alarm_flag; // R14

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_addr_ack: assert property (state == LSC_ADDR && byte_done && addr_hit && !start_c
    && !stop_c |=> sda_oe && state == LSC_ACK) else $error("no ack to own address"); // R1 R4
  a_foreign_addr: assert property (state == LSC_ADDR && byte_done && !addr_hit && !start_c
    && !stop_c |=> !sda_oe && state == LSC_IDLE) else $error("foreign address acked"); // R1
  a_cfg_holds: assert property (!(wr.stb && wr.idx == `LSC_OFS_OP_CFG) |=> $stable(cfg))
    else $error("command changed without write"); // R2
  a_data_together: assert property ($changed(light_count) || $changed(period_count)
    |-> $past(period_end)) else $error("data changed outside period end"); // R3 R22
  a_restart_clears: assert property (restart_cmd && active |=> integ_cnt == 16'h0000)
    else $error("restart did not restart integration"); // R5
  a_clear_alarm: assert property (clear_cmd && !alarm_set |=> !actl.alarm_flag)
    else $error("alarm not cleared"); // R6
  a_core_reset: assert property (!cfg.converter_run || cfg.device_sleep
    |=> integ_cnt == 16'h0000) else $error("counter runs while held"); // R7 R8
  a_internal_len: assert property (period_end && !restart_cmd
    |-> !cfg.timing_source_sel && integ_cnt == int_last) else $error("bad period"); // R10 R13
  a_alarm_sticky: assert property (actl.alarm_flag && !alarm_clr |=> actl.alarm_flag
    && int_oe) else $error("alarm dropped on its own"); // R21 R14
  a_set_wins: assert property (alarm_set |=> actl.alarm_flag)
    else $error("alarm event lost"); // R15 R17
  a_cfg_restart: assert property (cfg_wr |=> integ_cnt == 16'h0000) // R10
    else $error("config write did not restart the period");

  c_read_byte: cover property (state == LSC_RACK && scl_fall && !nack);
  c_write_byte: cover property (wr.stb);
  c_alarm_rise: cover property (!actl.alarm_flag ##1 actl.alarm_flag);
  c_ext_restart: cover property (restart_cmd && active && cfg.timing_source_sel);

endmodule // lsc_light_ctrl

/* tb/lsc_host.sv */
// i2c bus master model: drives scl, pulls sda low, reports each byte it reads
// assumes the bench resolves sda from all pull-downs plus a pull-up
`timescale 1ns/100ps
module lsc_host (
  input  wire logic       clock,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_pull,
  output logic            rx_stb,
  output logic [7:0]      rx_byte
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // 10 clocks per bit; data moves one clock into the low phase so setup stays >= 3 clocks
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_pull = ~b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    tick(1);
    scl = 1'b0;
  endtask
  // s = 0 gives a start, s = 1 a stop; sda moves while scl is high
  task automatic frame(input logic s);
    tick(1);
    sda_pull = s;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_pull = ~s;
    tick(5);
    if (!s) begin
      scl = 1'b0;
    end
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask
  // last byte gets a nack so the slave lets go before the stop
  task automatic get(input logic last);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
    rx_byte = d;
    rx_stb = 1'b1;
    tick(1);
    rx_stb = 1'b0;
  endtask
endmodule // lsc_host

/* tb/tb_top.sv */
// bench of the light sensor control: master model, sample source, queue of expected bytes
// assumes lsc_light_ctrl built with OSC_DIV 2 and lsc_host as the only master
`timescale 1ns/100ps
`include "lsc_regs.svh"
module tb_top;
  logic        clock = 1'b0;
  logic        rst_n;
  logic [15:0] photo_sample;
  logic [31:0] seed = 32'he9ac;
  logic [7:0]  wdat [8];
  logic [7:0]  expect_q [$];
  logic [7:0]  rstv [8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  ops [5] = '{8'h0b, 8'hcb, 8'h83, 8'h87, 8'h8f};
  logic [7:0]  ctls [4] = '{8'h09, 8'h0a, 8'h0b, 8'h05};
  logic [7:0]  keep;
  logic        a;
  int          num_errors = 0;
  int          total_checks = 0;
  int          c, m, p;
  wire logic   scl, sda_pull, sda_o, sda_oe, int_o, int_oe, rx_stb;
  wire logic [7:0] rx_byte;
  wire logic   sda = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
  wire logic   int_n = int_oe ? int_o : 1'b1;
  always #4 clock = ~clock;
  lsc_light_ctrl #(.OSC_DIV(2)) i_dut (.clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe), .photo_sample(photo_sample));
  lsc_host i_host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull), .rx_stb(rx_stb),
    .rx_byte(rx_byte));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic fail(input string s);
    num_errors++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fail($sformatf("read %h, expected %h", g, e));
    end
  endtask
  task automatic check_bit(input logic g, input logic e, input string s);
    total_checks++;
    if (g !== e) begin
      fail(s);
    end
  endtask
  task automatic print_verdict();
    if (expect_q.size() != 0) begin
      num_errors++;
    end
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic note(input logic [7:0] v);
    expect_q.push_back(v);
  endtask
  // write nw bytes of wdat from ptr, then repeated start and read nr bytes
  task automatic xfer(input logic [7:0] ptr, input int nw, input int nr);
    i_host.frame(1'b0);
    i_host.put({`LSC_SLAVE_ADDR, 1'b0}, a);
    check_bit(a, 1'b0, "address ack");
    i_host.put(ptr, a);
    check_bit(a, 1'b0, "pointer ack");
    for (int i = 0; i < nw; i++) begin
      i_host.put(wdat[i], a);
      check_bit(a, 1'b0, "data ack");
    end
    if (nr > 0) begin
      i_host.frame(1'b0);
      i_host.put({`LSC_SLAVE_ADDR, 1'b1}, a);
      check_bit(a, 1'b0, "read address ack");
      for (int i = 0; i < nr; i++) begin
        i_host.get(i == nr - 1);
      end
    end
    i_host.frame(1'b1);
  endtask
  // results come back whenever the master finishes reading a byte
  always @(posedge clock) begin
    if (rx_stb) begin
      if (expect_q.size() == 0) begin
        fail("unexpected read byte");
      end else begin
        check_byte(rx_byte, expect_q.pop_front());
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    photo_sample = 16'(xs());
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    i_host.tick(4);
    check_bit(int_n, 1'b1, "alarm pin after reset");
    for (int i = 0; i < 8; i++) begin
      note(rstv[i]);
    end
    xfer(8'h00, 0, 8);
    $display("test reset values done");
    for (int k = 0; k < 7; k++) begin
      i_host.frame(1'b0);
      i_host.put({`LSC_SLAVE_ADDR ^ (7'h01 << k), 1'b0}, a);
      check_bit(a, 1'b1, "foreign address acked");
      i_host.frame(1'b1);
    end
    $display("test address match done");
    wdat = '{8'hff, 8'hff, 8'(xs()), 8'(xs()), 8'(xs()), 8'h00, 8'h00, 8'h00};
    xfer(8'h00, 5, 0);
    note(8'hef);
    note(8'h0f);
    note(wdat[2]);
    note(wdat[3]);
    note(8'h00);
    xfer(8'h00, 0, 5);
    $display("test register access done");
    wdat[0] = 8'h08;
    wdat[1] = 8'hff;
    wdat[2] = 8'h00;
    xfer(8'h01, 3, 0);
    photo_sample = (16'(xs()) & 16'hfff7) | 16'h0001;
    wdat[0] = 8'h8b;
    xfer(8'h00, 1, 0);
    i_host.tick(200);
    note({4'h0, photo_sample[3:0]});
    note(8'h00);
    note(8'h0f);
    note(8'h00);
    xfer(8'h04, 0, 4);
    check_bit(int_n, 1'b1, "alarm inside window");
    wdat[0] = 8'h00;
    xfer(8'h02, 1, 0);
    i_host.tick(100);
    check_bit(int_n, 1'b0, "alarm above upper limit");
    wdat[0] = 8'hff;
    xfer(8'h02, 1, 0);
    i_host.tick(100);
    check_bit(int_n, 1'b0, "alarm dropped by itself");
    note(8'h28);
    xfer(8'h01, 0, 1);
    xfer(8'h41, 0, 0);
    i_host.tick(4);
    check_bit(int_n, 1'b1, "alarm clear by pointer");
    wdat[0] = 8'h01;
    xfer(8'h03, 1, 0);
    i_host.tick(100);
    check_bit(int_n, 1'b0, "alarm below lower limit");
    wdat[0] = 8'h00;
    wdat[1] = 8'h08;
    xfer(8'h03, 1, 0);
    xfer(8'h01, 2, 0);
    i_host.tick(4);
    check_bit(int_n, 1'b1, "alarm clear by flag write");
    $display("test window alarm done");
    for (int j = 0; j < 4; j++) begin
      m = (ctls[j][1:0] == 2'b01) ? 4 : (ctls[j][1:0] == 2'b10) ? 8 : 16;
      p = ctls[j][3] ? 32 : 64;
      wdat[0] = ctls[j];
      wdat[1] = 8'h00;
      xfer(8'h01, 2, 0);
      c = 0;
      while (int_n !== 1'b0 && c < m * p + 40) begin
        i_host.tick(1);
        c++;
      end
      check_bit(c >= m * p - p - 30 && c <= m * p + 4, 1'b1, "persistence delay");
      if (c >= m * p + 40) begin
        print_verdict();
      end
      wdat[0] = 8'hff;
      xfer(8'h02, 1, 0);
    end
    $display("test persistence done");
    photo_sample = 16'(xs()) | 16'h0008;
    keep = {4'hf, photo_sample[3:0]};
    wdat[0] = 8'hab;
    xfer(8'h00, 1, 0);
    xfer(8'h80, 0, 0);
    photo_sample = 16'(xs()) & 16'hfff7;
    i_host.tick(300);
    note(keep);
    note(8'hff);
    xfer(8'h04, 0, 2);
    xfer(8'h80, 0, 0);
    keep = {4'h0, photo_sample[3:0]};
    note(keep);
    note(8'h00);
    xfer(8'h04, 0, 2);
    $display("test host timing done");
    photo_sample = 16'(xs()) & 16'hff7f;
    keep = photo_sample[7:0];
    wdat[0] = 8'h8a;
    xfer(8'h00, 1, 0);
    i_host.tick(1200);
    note(keep);
    note(8'h00);
    note(8'hff);
    note(8'h00);
    xfer(8'h04, 0, 4);
    $display("test width done");
    for (int j = 0; j < 5; j++) begin
      wdat[0] = ops[j];
      xfer(8'h00, 1, 0);
      photo_sample = 16'(xs());
      i_host.tick(200);
      note(keep);
      note(8'h00);
      xfer(8'h04, 0, 2);
    end
    $display("test idle modes done");
    print_verdict();
  end
endmodule // tb_top
